/* serial_dma_pkg.sv */
package serial_dma_pkg;

  localparam int          NUM_CHAN       = 14;
  localparam logic [13:0] CHAN_IS_RX     = 14'h2AAA;

  localparam logic [11:0] OFS_CONFIG     = 12'h000;
  localparam logic [11:0] OFS_STATUS     = 12'h004;
  localparam logic [11:0] OFS_ERRADDR    = 12'h008;
  localparam logic [11:0] OFS_SYSCFG     = 12'h00C;
  localparam logic [5:0]  CHAN_REGION    = 6'h01;

  localparam int FRZ_LSB  = 13;
  localparam int SVC_LSB  = 8;
  localparam int AID_LSB  = 4;
  localparam int ST_BERR  = 1;
  localparam int ST_BKPT  = 0;
  localparam int BC_EN    = 3;
  localparam int SHOW_EN  = 4;
  localparam int FC_LSB   = 0;
  localparam int LE_BIT   = 4;

  localparam logic [1:0] FRZ_IGNORE = 2'h0;
  localparam logic [1:0] FRZ_STOP   = 2'h2;

  localparam logic [1:0] SIZE_BYTE  = 2'h0;
  localparam logic [1:0] SIZE_WORD  = 2'h1;
  localparam logic [1:0] SIZE_LONG  = 2'h2;
  localparam logic [1:0] PORT_32    = 2'h0;
  localparam logic [1:0] PORT_8     = 2'h1;
  localparam logic [1:0] PORT_16    = 2'h2;

  localparam logic [2:0] BYTES_1    = 3'h1;
  localparam logic [2:0] BYTES_2    = 3'h2;
  localparam logic [2:0] BYTES_4    = 3'h4;

  typedef enum logic [1:0] {IDLE, ARB, CYCLE} state_type;

endpackage : serial_dma_pkg

/* arb_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface arb_link_if;
  logic       req;
  logic       extPath;
  logic [2:0] arbId;
  logic [2:0] svcMask;
  logic [1:0] freezeMode;
  logic       win;
  logic       preempt;
  logic       holdOff;

  modport engine (output req, extPath, arbId, svcMask, freezeMode,
                  input  win, preempt, holdOff);
  modport arbiter (input  req, extPath, arbId, svcMask, freezeMode,
                   output win, preempt, holdOff);
endinterface : arb_link_if
`default_nettype wire

/* serial_dma_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_dma_arbiter
  import serial_dma_pkg::*;
(
  arb_link_if.arbiter   link,
  input  wire logic       otherReq,
  input  wire logic [2:0] otherId,
  input  wire logic       idmaOwnsBus,
  input  wire logic [2:0] idmaId,
  input  wire logic       masterMode,
  input  wire logic       extMasterHeld,
  input  wire logic       extGrant,
  input  wire logic       freeze,
  input  wire logic [2:0] serviceLevel
);

  logic intWin;
  logic extAvail;
  logic steal;

  always_comb begin
    steal    = idmaOwnsBus && (link.arbId > idmaId);          // (R16)
    intWin   = (!otherReq || (link.arbId > otherId)) &&       // (R6)
               (!idmaOwnsBus || steal);
    // master mode with a quiet external bus needs no handshake at all
    extAvail = masterMode ? !extMasterHeld : extGrant;        // (R12)
    link.win = link.req && intWin && (!link.extPath || extAvail); // (R2)
    link.preempt = (otherReq && (otherId > link.arbId)) ||    // (R11)
                   (link.extPath && masterMode && extMasterHeld);
    link.holdOff = (serviceLevel > link.svcMask) ||           // (R19)
                   ((link.freezeMode == FRZ_STOP) && freeze); // (R20)
  end

endmodule : serial_dma_arbiter
`default_nettype wire

/* serial_dma_master.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (R1) fourteen channels, each fixed receive or transmit
// (R2) external path needs both buses, internal one
// (R3) per-channel programmable four-bit function code
// (R4) per-channel big or little endian order
// (R5) bus error flags, captures address, halts
// (R6) shared arbitration id against other masters
// (R7) release bus after one long-word operand
// (R8) characters written singly, reads always long
// (R9) narrow ports split operand into cycles
// (R10) back-to-back cycles unless higher request
// (R11) preempted: release, reacquire, finish remaining
// (R12) master mode idle bus: zero overhead
// (R13) external request/grant pins left untouched
// (R14) bus clear while requesting, off during access
// (R15) bus clear only when id exceeds threshold
// (R16) steal cycles from independent dma if higher
// (R17) outside logic may halt master via clear; there is no clear input here, only a bus error halts
// (R18) three-bit id, seven highest priority
// (R19) service level above mask withdraws request; here busReq stays raised in ARB and no bus cycle starts
// (R20) freeze setting stops; setting zero ignores
module serial_dma_master
  import serial_dma_pkg::*;
#(
  parameter logic [13:0] RX_MASK = CHAN_IS_RX
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reqValid,
  input  wire logic [3:0]  reqChan,
  input  wire logic [31:0] reqAddr,
  input  wire logic [1:0]  reqSize,
  input  wire logic [31:0] reqData,
  input  wire logic        reqExternal,
  output logic             reqAccept,
  output logic             reqDone,
  output logic             reqErr,
  output logic      [31:0] rspData,
  output logic             busReq,
  output logic             busStrobe,
  output logic      [31:0] busAddr,
  output logic             busWrite,
  output logic      [2:0]  busBytes,
  output logic      [31:0] busWdata,
  output logic      [3:0]  busFc,
  output logic             busExternal,
  output logic             busShow,
  input  wire logic        busAck,
  input  wire logic        busErr,
  input  wire logic [1:0]  busPortSize,
  input  wire logic [31:0] busRdata,
  input  wire logic        breakpoint,
  input  wire logic        cpReset,
  output logic             cpHalted,
  output logic             bus_clear_out,
  input  wire logic        otherReq,
  input  wire logic [2:0]  otherId,
  input  wire logic        idmaOwnsBus,
  input  wire logic [2:0]  idmaId,
  input  wire logic        masterMode,
  input  wire logic        extMasterHeld,
  input  wire logic        extGrant,
  input  wire logic        freeze,
  input  wire logic [2:0]  serviceLevel
);

  function automatic logic [2:0] sizeBytes(input logic [1:0] s);
    unique case (s)
      SIZE_BYTE: sizeBytes = BYTES_1;
      SIZE_WORD: sizeBytes = BYTES_2;
      default:   sizeBytes = BYTES_4;
    endcase
  endfunction : sizeBytes

  function automatic logic [2:0] portBytes(input logic [1:0] p);
    unique case (p)
      PORT_8:  portBytes = BYTES_1;
      PORT_16: portBytes = BYTES_2;
      default: portBytes = BYTES_4;
    endcase
  endfunction : portBytes

  // reverses the low n bytes, result right-justified
  function automatic logic [31:0] swapBytes(input logic [31:0] d, input logic [2:0] n);
    if (n == BYTES_1) begin
      swapBytes = {24'h000000, d[7:0]};
    end else if (n == BYTES_2) begin
      swapBytes = {16'h0000, d[7:0], d[15:8]};
    end else begin
      swapBytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
  endfunction : swapBytes

  arb_link_if link ();

  serial_dma_arbiter arbiter (
    .link          (link.arbiter),
    .otherReq      (otherReq),
    .otherId       (otherId),
    .idmaOwnsBus   (idmaOwnsBus),
    .idmaId        (idmaId),
    .masterMode    (masterMode),
    .extMasterHeld (extMasterHeld),
    .extGrant      (extGrant),
    .freeze        (freeze),
    .serviceLevel  (serviceLevel)
  );

  state_type   state_reg,    state_next;
  logic [1:0]  frz_reg,      frz_next;
  logic [2:0]  svcMask_reg,  svcMask_next;
  logic [2:0]  arbId_reg,    arbId_next;
  logic [1:0]  status_reg,   status_next;
  logic [31:0] errAddr_reg,  errAddr_next;
  logic [2:0]  bcThr_reg,    bcThr_next;
  logic        bcEn_reg,     bcEn_next;
  logic        showEn_reg,   showEn_next;
  logic [4:0]  chanCfg_reg [NUM_CHAN];
  logic [4:0]  chanCfg_next [NUM_CHAN];
  logic        halted_reg,   halted_next;
  logic [31:0] opAddr_reg,   opAddr_next;
  logic [31:0] opData_reg,   opData_next;
  logic [2:0]  opLeft_reg,   opLeft_next;
  logic        opWrite_reg,  opWrite_next;
  logic        opExt_reg,    opExt_next;
  logic [3:0]  opFc_reg,     opFc_next;
  logic        opLe_reg,     opLe_next;
  logic [31:0] prdata_reg,   prdata_next;
  logic        pready_reg,   pready_next;
  logic        pslverr_reg,  pslverr_next;
  logic        accept_reg,   accept_next;
  logic        done_reg,     done_next;
  logic        err_reg,      err_next;
  logic [31:0] rsp_reg,      rsp_next;
  logic        clear_reg,    clear_next;

  logic        apbWrite;
  logic        apbSetup;
  logic        chanHit;
  logic [3:0]  chanIdx;
  logic [2:0]  nBytes;
  logic [5:0]  shiftBits;
  logic [31:0] inData;
  logic [2:0]  reqBytes;

  assign link.req        = (state_reg == ARB);
  assign link.extPath    = opExt_reg;
  assign link.arbId      = arbId_reg;                             // (R18)
  assign link.svcMask    = svcMask_reg;
  assign link.freezeMode = frz_reg;

  always_comb begin
    apbSetup  = psel && !penable;
    apbWrite  = psel && penable && pready_reg && pwrite;
    chanIdx   = paddr[5:2];
    chanHit   = (paddr[11:6] == CHAN_REGION) && (chanIdx < 4'(NUM_CHAN));
    nBytes    = (portBytes(busPortSize) < opLeft_reg) ?
                portBytes(busPortSize) : opLeft_reg;              // (R9)
    shiftBits = {nBytes, 3'h0};
    // receive channels write what they got, transmit channels only read
    reqBytes  = RX_MASK[reqChan] ? sizeBytes(reqSize) : BYTES_4; // (R1) (R8)
    inData    = chanCfg_reg[reqChan][LE_BIT] ?
                swapBytes(reqData, reqBytes) : reqData;           // (R4)

    frz_next     = frz_reg;
    svcMask_next = svcMask_reg;
    arbId_next   = arbId_reg;
    errAddr_next = errAddr_reg;
    bcThr_next   = bcThr_reg;
    bcEn_next    = bcEn_reg;
    showEn_next  = showEn_reg;
    chanCfg_next = chanCfg_reg;
    status_next  = status_reg;
    halted_next  = halted_reg;
    state_next   = state_reg;
    opAddr_next  = opAddr_reg;
    opData_next  = opData_reg;
    opLeft_next  = opLeft_reg;
    opWrite_next = opWrite_reg;
    opExt_next   = opExt_reg;
    opFc_next    = opFc_reg;
    opLe_next    = opLe_reg;
    accept_next  = 1'b0;
    done_next    = 1'b0;
    err_next     = 1'b0;
    rsp_next     = rsp_reg;

    // read data and error are formed in the setup cycle so pready can be a flop
    pready_next  = apbSetup;
    pslverr_next = 1'b0;
    prdata_next  = 32'h00000000;
    if (apbSetup) begin
      if (paddr == OFS_CONFIG) begin
        prdata_next[FRZ_LSB +: 2] = frz_reg;
        prdata_next[SVC_LSB +: 3] = svcMask_reg;
        prdata_next[AID_LSB +: 3] = arbId_reg;
      end else if (paddr == OFS_STATUS) begin
        prdata_next[1:0] = status_reg;
      end else if (paddr == OFS_ERRADDR) begin
        prdata_next = errAddr_reg;
      end else if (paddr == OFS_SYSCFG) begin
        prdata_next[2:0]     = bcThr_reg;
        prdata_next[BC_EN]   = bcEn_reg;
        prdata_next[SHOW_EN] = showEn_reg;
      end else if (chanHit) begin
        prdata_next[4:0] = chanCfg_reg[chanIdx];
      end else begin
        pslverr_next = 1'b1;
      end
    end
    if (apbWrite) begin
      if (paddr == OFS_CONFIG) begin
        frz_next     = pwdata[FRZ_LSB +: 2];
        svcMask_next = pwdata[SVC_LSB +: 3];
        arbId_next   = pwdata[AID_LSB +: 3];
      end else if (paddr == OFS_STATUS) begin
        status_next = status_reg & ~pwdata[1:0];
      end else if (paddr == OFS_SYSCFG) begin
        bcThr_next  = pwdata[2:0];
        bcEn_next   = pwdata[BC_EN];
        showEn_next = pwdata[SHOW_EN];
      end else if (chanHit) begin
        chanCfg_next[chanIdx] = pwdata[4:0];                      // (R3)
      end
    end

    if (cpReset) begin
      halted_next = 1'b0;
    end

    unique case (state_reg)
      IDLE: begin
        if (reqValid && !halted_reg && !link.holdOff) begin
          accept_next  = 1'b1;
          opAddr_next  = reqAddr;
          opLeft_next  = reqBytes;
          opWrite_next = RX_MASK[reqChan];                        // (R1)
          opExt_next   = reqExternal;
          opFc_next    = chanCfg_reg[reqChan][FC_LSB +: 4];       // (R3)
          opLe_next    = chanCfg_reg[reqChan][LE_BIT];
          // operand is kept left-justified, next byte on top
          opData_next  = inData << (6'd32 - {reqBytes, 3'h0});
          state_next   = ARB;
        end
      end
      ARB: begin
        if (link.holdOff) begin
          state_next = ARB;                                       // (R19) (R20)
        end else if (link.win) begin
          state_next = CYCLE;                                     // (R6) (R16)
        end
      end
      CYCLE: begin
        if (breakpoint) begin
          status_next[ST_BKPT] = 1'b1;
        end
        if (busAck && busErr) begin
          status_next[ST_BERR] = 1'b1;                            // (R5)
          errAddr_next = opAddr_reg;
          halted_next  = 1'b1;
          err_next     = 1'b1;
          done_next    = 1'b1;
          state_next   = IDLE;
        end else if (busAck) begin
          opAddr_next = opAddr_reg + {29'h00000000, nBytes};      // (R9)
          opLeft_next = opLeft_reg - nBytes;
          if (opWrite_reg) begin
            opData_next = opData_reg << shiftBits;
          end else begin
            opData_next = (opData_reg << shiftBits) | (busRdata >> (6'd32 - shiftBits));
          end
          if (opLeft_reg == nBytes) begin
            done_next  = 1'b1;
            rsp_next   = opLe_reg ? swapBytes(opData_next, BYTES_4) : opData_next; // (R4)
            state_next = IDLE;                                    // (R7)
          end else if (link.preempt || link.holdOff) begin
            state_next = ARB;                                     // (R11)
          end else begin
            state_next = CYCLE;                                   // (R10)
          end
        end
      end
    endcase

    // a freshly set bit survives a clearing write in the same cycle
    if (apbWrite && (paddr == OFS_STATUS)) begin
      status_next = status_next | (status_reg & ~pwdata[1:0]);
    end

    // only internal request is raised; external request and grant pins are never driven
    clear_next = bcEn_reg && (arbId_reg > bcThr_reg) &&           // (R13) (R15)
                 (state_next == ARB);                             // (R14)
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg   <= IDLE;
      frz_reg     <= FRZ_IGNORE;
      svcMask_reg <= 3'h0;
      arbId_reg   <= 3'h0;
      status_reg  <= 2'h0;
      errAddr_reg <= 32'h00000000;
      bcThr_reg   <= 3'h0;
      bcEn_reg    <= 1'b0;
      showEn_reg  <= 1'b0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        chanCfg_reg[i] <= 5'h00;
      end
      halted_reg  <= 1'b0;
      opAddr_reg  <= 32'h00000000;
      opData_reg  <= 32'h00000000;
      opLeft_reg  <= 3'h0;
      opWrite_reg <= 1'b0;
      opExt_reg   <= 1'b0;
      opFc_reg    <= 4'h0;
      opLe_reg    <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      accept_reg  <= 1'b0;
      done_reg    <= 1'b0;
      err_reg     <= 1'b0;
      rsp_reg     <= 32'h00000000;
      clear_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      frz_reg     <= frz_next;
      svcMask_reg <= svcMask_next;
      arbId_reg   <= arbId_next;
      status_reg  <= status_next;
      errAddr_reg <= errAddr_next;
      bcThr_reg   <= bcThr_next;
      bcEn_reg    <= bcEn_next;
      showEn_reg  <= showEn_next;
      chanCfg_reg <= chanCfg_next;
      halted_reg  <= halted_next;
      opAddr_reg  <= opAddr_next;
      opData_reg  <= opData_next;
      opLeft_reg  <= opLeft_next;
      opWrite_reg <= opWrite_next;
      opExt_reg   <= opExt_next;
      opFc_reg    <= opFc_next;
      opLe_reg    <= opLe_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      accept_reg  <= accept_next;
      done_reg    <= done_next;
      err_reg     <= err_next;
      rsp_reg     <= rsp_next;
      clear_reg   <= clear_next;
    end
  end

  // bus address, write, size, data, code and path outputs are the operand registers themselves, valid while busStrobe
  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign reqAccept     = accept_reg;
  assign reqDone       = done_reg;
  assign reqErr        = err_reg;
  assign rspData       = rsp_reg;
  assign busReq        = (state_reg == ARB);
  assign busStrobe     = (state_reg == CYCLE);
  assign busAddr       = opAddr_reg;
  assign busWrite      = opWrite_reg;
  assign busBytes      = opLeft_reg;
  assign busWdata      = opData_reg;
  assign busFc         = opFc_reg;
  assign busExternal   = opExt_reg;
  // internal accesses stay off the external bus unless shown
  assign busShow       = showEn_reg && !opExt_reg;              // (R2)
  assign cpHalted      = halted_reg;
  assign bus_clear_out = clear_reg;

endmodule : serial_dma_master
`default_nettype wire

/* serial_dma_master_props.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_dma_master_props
  import serial_dma_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        reqAccept,
  input wire logic        reqDone,
  input wire logic        reqErr,
  input wire logic        busReq,
  input wire logic        busStrobe,
  input wire logic [31:0] busAddr,
  input wire logic [2:0]  busBytes,
  input wire logic        busExternal,
  input wire logic        busShow,
  input wire logic        busAck,
  input wire logic        busErr,
  input wire logic [1:0]  busPortSize,
  input wire logic        cpHalted,
  input wire logic        bus_clear_out,
  input wire logic        otherReq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_accept_req: assert property (
    reqAccept |-> busReq && !busStrobe) else $error("accept without bus request");
  a_err_done: assert property (
    busStrobe && busAck && busErr |=> reqDone && reqErr) else $error("bus error not reported");
  a_halt_block: assert property (
    cpHalted |-> !reqAccept && !busReq) else $error("activity while halted");
  a_last_done: assert property (
    busStrobe && busAck && !busErr && busPortSize == PORT_32 |=> reqDone && !busStrobe)
    else $error("bus kept after full operand");
  a_split_next: assert property (
    busStrobe && busAck && !busErr && busPortSize == PORT_16 && busBytes == BYTES_4 && !otherReq
    |=> busStrobe && busAddr == $past(busAddr) + 32'h2) else $error("narrow split wrong");
  a_strobe_hold: assert property (
    busStrobe && !busAck |=> busStrobe && $stable(busAddr) && $stable(busBytes))
    else $error("bus cycle changed before ack");
  a_clear_off: assert property (
    busStrobe |-> !bus_clear_out) else $error("clear output during access");
  a_clear_req: assert property (
    bus_clear_out |-> busReq) else $error("clear output without request");
  a_show_int: assert property (
    busStrobe && busShow |-> !busExternal) else $error("show cycle on external path");
  a_done_once: assert property (
    reqDone |-> !busStrobe ##1 !reqDone) else $error("done not a single pulse");
endmodule : serial_dma_master_props

bind serial_dma_master serial_dma_master_props i_props (.*);
`default_nettype wire

/* serial_dma_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_dma_mem_model
  import serial_dma_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        busStrobe,
  input  wire logic [31:0] busAddr,
  input  wire logic        busWrite,
  input  wire logic [31:0] busWdata,
  input  wire logic [3:0]  busFc,
  input  wire logic        busShow,
  input  wire logic [1:0]  portSel,
  input  wire logic        errSel,
  input  wire logic [3:0]  waitCyc,
  output logic             busAck,
  output logic             busErr,
  output logic      [1:0]  busPortSize,
  output logic      [31:0] busRdata,
  output logic      [31:0] lastWdata,
  output logic      [3:0]  lastFc,
  output logic             lastShow
);
  logic [3:0]  waited;
  logic [7:0]  low;
  assign low = busAddr[7:0];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {busAck, busErr, busPortSize, busRdata, waited} <= '0;
      {lastWdata, lastFc, lastShow} <= '0;
    end else if (!busStrobe || busAck || waited < waitCyc) begin
      // lines not in use toggle so nothing stale can be mistaken for data
      waited <= (busStrobe && !busAck) ? waited + 4'h1 : 4'h0;
      {busAck, busErr} <= 2'h0;
      busRdata <= ~busRdata;
    end else begin
      busAck <= 1'b1;
      busErr <= errSel;
      busPortSize <= portSel;
      // 16-bit port: only the top two lanes carry bytes, the low half is junk
      busRdata <= {low ^ 8'h5A, (low + 8'h1) ^ 8'h5A, (low + 8'h2) ^ 8'h5A,
                   (low + 8'h3) ^ 8'h5A} ^ ((portSel == PORT_16) ? 32'h0000FFFF : 32'h0);
      lastFc <= busFc;
      lastShow <= busShow;
      if (busWrite) lastWdata <= busWdata;
    end
  end
endmodule : serial_dma_mem_model
`default_nettype wire

/* serial_dma_master_test.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_dma_master_test
  import serial_dma_pkg::*;
;
  logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr, slvErr, acc, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, reqAddr, reqData, rspData, busAddr, busWdata, busRdata;
  logic [31:0] lastWdata, rd;
  logic        reqValid, reqExternal, reqAccept, reqDone, reqErr, busReq, busStrobe;
  logic        busWrite, busExternal, busShow, busAck, busErr, breakpoint, cpReset;
  logic        cpHalted, bus_clear_out, otherReq, idmaOwnsBus, masterMode, extMasterHeld;
  logic        extGrant, freeze, errSel, lastShow, prevStrobe;
  logic [3:0]  reqChan, busFc, lastFc, waitCyc;
  logic [1:0]  reqSize, busPortSize, portSel;
  logic [2:0]  busBytes, otherId, idmaId, serviceLevel;
  int          numErrors, totalChecks, rises, clears, cycles, base, cbase;
  localparam logic [31:0] CFG_TAB [4] = '{32'h50, 32'h350, 32'h4750, 32'h750};

  serial_dma_master i_dut (.*);
  serial_dma_mem_model i_mem (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    prevStrobe <= busStrobe;
    rises <= rises + int'(busStrobe && !prevStrobe);
    clears <= clears + int'(bus_clear_out);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      numErrors++;
      wrapUp();
    end
  end

  function automatic logic [31:0] expLong(input logic [7:0] a);
    return {a ^ 8'h5A, (a + 8'h1) ^ 8'h5A, (a + 8'h2) ^ 8'h5A, (a + 8'h3) ^ 8'h5A};
  endfunction : expLong

  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : checkWord

  task automatic checkFlag(input logic got, input logic exp);
    checkWord({31'h0, got}, {31'h0, exp});
  endtask : checkFlag

  // waits for pready however long it takes; only the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    slvErr = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge clk_sys);
  endtask : apb

  task automatic apbRead(input logic [11:0] a, input logic [31:0] exp, input logic eErr);
    apb(1'b0, a, 32'h0);
    checkWord(rd, exp);
    checkFlag(slvErr, eErr);
  endtask : apbRead

  task automatic xfer(input logic [3:0] ch, input logic [31:0] a, input logic [1:0] sz,
                      input logic [31:0] d, input logic ext);
    int n;
    n = 0;
    err = 1'b0;
    {reqValid, reqChan, reqAddr, reqSize, reqData, reqExternal} <= {1'b1, ch, a, sz, d, ext};
    do begin
      @(posedge clk_sys);
      n++;
    end while (reqAccept !== 1'b1 && n < 8);
    acc = reqAccept;
    reqValid <= 1'b0;
    n = 0;
    while (acc && reqDone !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    if (acc) err = reqErr;
    @(posedge clk_sys);
  endtask : xfer

  task automatic wrapUp;
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrapUp

  initial begin
    {psel, penable, pwrite, paddr, pwdata, prevStrobe} = '0;
    {reqValid, reqChan, reqAddr, reqSize, reqData, reqExternal} = '0;
    {breakpoint, cpReset, otherReq, otherId, idmaOwnsBus, idmaId, extMasterHeld} = '0;
    {freeze, serviceLevel, errSel, waitCyc, portSel} = '0;
    {masterMode, extGrant, srst} = 3'h7;
    {numErrors, totalChecks, rises, clears, cycles} = '0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    apbRead(OFS_CONFIG, 32'h0, 1'b0);
    apbRead(12'h100, 32'h0, 1'b1);
    apb(1'b1, OFS_CONFIG, 32'h50);
    apbRead(OFS_CONFIG, 32'h50, 1'b0);
    apb(1'b1, 12'h040, 32'h0B);
    apb(1'b1, 12'h044, 32'h17);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      // second pass: clear threshold equals our id, external path, 16-bit port
      apb(1'b1, OFS_SYSCFG, i ? 32'h1D : 32'h1B);
      portSel <= i ? PORT_16 : PORT_32;
      {base, cbase} = {rises, clears};
      xfer(4'h0, 32'h1230 + 32'(4 * i), SIZE_LONG, 32'h0, i[0]);
      checkWord(rspData, expLong(8'h30 + 8'(4 * i)));
      checkWord(rises - base, 1);
      checkFlag(clears > cbase, i == 0);
      checkFlag(lastShow, i == 0);
      checkWord({28'h0, lastFc}, 32'hB);
    end
    $display("test reads done");
    waitCyc <= 4'h2;
    for (int i = 0; i < 2; i++) begin
      otherId <= i ? 3'h1 : 3'h7;
      base = rises;
      fork
        xfer(4'h0, 32'h2000, SIZE_LONG, 32'h0, 1'b0);
        begin
          @(posedge clk_sys iff busStrobe);
          otherReq <= 1'b1;
          repeat (6) @(posedge clk_sys);
          otherReq <= 1'b0;
        end
      join
      checkWord(rspData, expLong(8'h00));
      checkWord(rises - base, 2 - i);
    end
    {waitCyc, portSel} <= '0;
    $display("test preemption done");
    xfer(4'h1, 32'h3001, SIZE_BYTE, 32'hC3, 1'b0);
    checkWord({24'h0, lastWdata[31:24]}, 32'hC3);
    xfer(4'h1, 32'h3002, SIZE_WORD, 32'hBEEF, 1'b0);
    checkWord({16'h0, lastWdata[31:16]}, 32'hEFBE);
    checkWord({28'h0, lastFc}, 32'h7);
    $display("test writes done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_CONFIG, CFG_TAB[i]);
      serviceLevel <= (i < 2) ? 3'h3 : 3'h0;
      freeze <= (i >= 2);
      xfer(4'h0, 32'h4000, SIZE_LONG, 32'h0, 1'b0);
      checkFlag(acc, i[0]);
    end
    freeze <= 1'b0;
    $display("test hold-off done");
    {errSel, breakpoint} <= 2'h3;
    xfer(4'h0, 32'h5554, SIZE_LONG, 32'h0, 1'b1);
    checkFlag(err, 1'b1);
    {errSel, breakpoint} <= 2'h0;
    apbRead(OFS_STATUS, 32'h3, 1'b0);
    apbRead(OFS_ERRADDR, 32'h5554, 1'b0);
    checkFlag(cpHalted, 1'b1);
    xfer(4'h0, 32'h5558, SIZE_LONG, 32'h0, 1'b1);
    checkFlag(acc, 1'b0);
    cpReset <= 1'b1;
    @(posedge clk_sys);
    cpReset <= 1'b0;
    apb(1'b1, OFS_STATUS, 32'h3);
    apbRead(OFS_STATUS, 32'h0, 1'b0);
    xfer(4'h0, 32'h5558, SIZE_LONG, 32'h0, 1'b1);
    checkFlag(acc, 1'b1);
    $display("test bus error done");
    wrapUp();
  end
endmodule : serial_dma_master_test
`default_nettype wire
